// ---- bench/pto_field.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Field contacts and retention memory
// ----------------------------------------------------------------
module pto_field (
  input  wire logic        hclk,
  input  wire logic [24:0] nv_word,
  input  wire logic        nv_save,
  output logic             gate_in,
  output logic             reset_in,
  output logic             power_fail_in,
  output logic      [24:0] nv_word_in,
  output logic             nv_valid_in
);
  logic [24:0] mem_q = 25'h0;
  logic        valid_q = 1'b0;
  initial begin
    gate_in = 1'b1;
    reset_in = 1'b0;
    power_fail_in = 1'b0;
  end
  always @(posedge hclk) begin
    if (nv_save) begin
      mem_q <= nv_word;
      valid_q <= 1'b1;
    end
  end
  // Unwritten memory shows garbage, not the last word
  assign nv_word_in = valid_q ? mem_q : ~mem_q;
  assign nv_valid_in = valid_q;
  task automatic set_gate(input logic v);
    gate_in <= v;
  endtask
  task automatic pulse(input logic pwr);
    if (pwr) power_fail_in <= 1'b1;
    else reset_in <= 1'b1;
    repeat (8) @(posedge hclk);
    power_fail_in <= 1'b0;
    reset_in <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
endmodule // pto_field
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pto_cfg.svh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hsel = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hrdata, rv, c0;
  logic        hreadyout, hresp, gate_in, reset_in, power_fail_in;
  logic        nv_valid_in, nv_save, out1, out2, irq;
  logic [24:0] nv_word_in, nv_word;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #25 hclk = ~hclk;

  pto_timer #(.MS_CYC(20)) pto_timer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .gate_in(gate_in), .reset_in(reset_in),
    .power_fail_in(power_fail_in), .nv_word_in(nv_word_in),
    .nv_valid_in(nv_valid_in), .nv_word(nv_word), .nv_save(nv_save),
    .out1(out1), .out2(out2), .irq(irq));

  pto_field pto_field_i (
    .hclk(hclk), .nv_word(nv_word), .nv_save(nv_save), .gate_in(gate_in),
    .reset_in(reset_in), .power_fail_in(power_fail_in),
    .nv_word_in(nv_word_in), .nv_valid_in(nv_valid_in));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rv, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    // A transfer without select must leave the registers alone
    haddr <= {24'h0, `PTO_LIM1_OFS};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wt(1);
    htrans <= 2'h0;
    hwdata <= 32'h5;
    wt(1);
    rc(`PTO_LIM1_OFS, 32'h0);
    rc(`PTO_CTRL_OFS, 32'h0);
    rc(8'h40, 32'h0);
  endtask
  task automatic t_auto1;
    wr(`PTO_LIM1_OFS, 32'h2);
    wr(`PTO_LIM2_OFS, 32'h5);
    wr(`PTO_CTRL_OFS, 32'h413);
    wt(1300);
    chk({31'h0, out1}, 32'h1);
    chk({31'h0, out2}, 32'h1);
    rc(`PTO_TOT_OFS, 32'h5);
    wt(1000);
    rc(`PTO_TOT_OFS, 32'ha);
    wr(`PTO_CTRL_OFS, 32'h193);
    wt(2);
    chk({30'h0, out2, out1}, 32'h0);
  endtask
  task automatic t_man2;
    wr(`PTO_CTRL_OFS, 32'h411);
    wr(`PTO_ICLR_OFS, 32'hf);
    wr(`PTO_IEN_OFS, 32'h2);
    wt(1300);
    rc(`PTO_CNT_OFS, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(`PTO_ICLR_OFS, 32'h2);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    pto_field_i.pulse(1'b0);
    rc(`PTO_CNT_OFS, 32'h0);
    pto_field_i.set_gate(1'b0);
    wt(8);
    wr(`PTO_CTRL_OFS, 32'h051);
    wr(`PTO_CTRL_OFS, 32'h451);
    rc(`PTO_CNT_OFS, 32'h5);
    wt(600);
    rc(`PTO_CNT_OFS, 32'h5);
    pto_field_i.set_gate(1'b1);
    wt(500);
    xfer(`PTO_CNT_OFS, 1'b0, 32'h0);
    chk({31'h0, rv < 32'h5}, 32'h1);
  endtask
  task automatic t_pwr;
    pto_field_i.set_gate(1'b0);
    wt(8);
    wr(`PTO_CTRL_OFS, 32'h251);
    xfer(`PTO_CNT_OFS, 1'b0, 32'h0);
    c0 = rv;
    pto_field_i.pulse(1'b1);
    hresetn <= 1'b0;
    wt(3);
    hresetn <= 1'b1;
    wt(2);
    rc(`PTO_CNT_OFS, c0);
  endtask
  task automatic t_pass;
    wr(`PTO_LIM1_OFS, 32'h7);
    wr(`PTO_PASS_OFS, 32'h9);
    wr(`PTO_LIM1_OFS, 32'h3);
    rc(`PTO_LIM1_OFS, 32'h7);
    rc(`PTO_UNLK_OFS, 32'h0);
    wr(`PTO_CTRL_OFS, 32'h003);
    rc(`PTO_CTRL_OFS, 32'h0);
    wr(`PTO_UNLK_OFS, 32'h9);
    wr(`PTO_LIM1_OFS, 32'h3);
    rc(`PTO_LIM1_OFS, 32'h3);
  endtask

  task automatic wo(input logic sel, input logic lvl);
    for (int i = 0; i < 2000; i++) begin
      if ((sel ? out2 : out1) === lvl) break;
      @(posedge hclk);
    end
  endtask
  task automatic t_pulse;
    pto_field_i.set_gate(1'b1);
    wr(`PTO_PULSE_OFS, 32'h00020003);
    wr(`PTO_LIM1_OFS, 32'h2);
    wr(`PTO_LIM2_OFS, 32'h3);
    wr(`PTO_CTRL_OFS, 32'h415);
    wt(2);
    wo(1'b1, 1'b1);
    rc(`PTO_DISP_OFS, 32'h3);
    wt(50);
    rc(`PTO_DISP_OFS, 32'h0);
    chk({31'h0, out2}, 32'h0);
    wr(`PTO_CTRL_OFS, 32'h416);
    wt(2);
    wo(1'b1, 1'b1);
    chk({31'h0, out1}, 32'h0);
    wt(50);
    rc(`PTO_CNT_OFS, 32'h0);
    chk({31'h0, out2}, 32'h0);
    wr(`PTO_CTRL_OFS, 32'h417);
    wt(2);
    wo(1'b0, 1'b1);
    chk({31'h0, out1}, 32'h1);
    chk({31'h0, out2}, 32'h0);
    wo(1'b0, 1'b0);
    chk({31'h0, out1}, 32'h0);
  endtask

  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude;
    end
  end

  initial begin
    wt(8);
    hresetn <= 1'b1;
    wt(1);
    t_regs;
    t_auto1;
    t_man2;
    t_pwr;
    t_pass;
    t_pulse;
    conclude;
  end
endmodule // tb
`default_nettype wire

// ---- verilog/pto_cfg.svh ----
`ifndef PTO_CFG_SVH
`define PTO_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PTO_CTRL_OFS  8'h00
`define PTO_LIM1_OFS  8'h04
`define PTO_LIM2_OFS  8'h08
`define PTO_PULSE_OFS 8'h0c
`define PTO_PASS_OFS  8'h10
`define PTO_UNLK_OFS  8'h14
`define PTO_CNT_OFS   8'h18
`define PTO_DISP_OFS  8'h1c
`define PTO_TOT_OFS   8'h20
`define PTO_STAT_OFS  8'h24
`define PTO_IST_OFS   8'h28
`define PTO_ICLR_OFS  8'h2c
`define PTO_IEN_OFS   8'h30

// ----------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------
`define PTO_CTRL_SWRST 10
`define PTO_P2_LSB     16
`define PTO_VAL_MAX    14'h270f
`define PTO_LO59       8'h3b
`define PTO_LO99       8'h63
`define PTO_HI99       17'h00063
`define PTO_HI9999     17'h0270f
`define PTO_HI99999    17'h1869f

// ----------------------------------------------------------------
// Scale and output function codes
// ----------------------------------------------------------------
`define PTO_SC_HM   3'h0
`define PTO_SC_MS   3'h1
`define PTO_SC_SMS  3'h2
`define PTO_SC_HM2  3'h3
`define PTO_SC_H    3'h4
`define PTO_SC_M    3'h5
`define PTO_SC_S    3'h6
`define PTO_FN_MAN1 3'h0
`define PTO_FN_MAN2 3'h1
`define PTO_FN_MAN3 3'h2
`define PTO_FN_AUT1 3'h3
`define PTO_FN_AUT2 3'h4
`define PTO_FN_AUT3 3'h5
`define PTO_FN_AUT4 3'h6
`define PTO_FN_AUT5 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTO_CLK_MHZ    20
`define PTO_TICK_US    1000
`define PTO_MS_PER_CS  4'ha
`define PTO_CS_PER_S   7'h64
`define PTO_S_PER_MIN  6'h3c
`define PTO_MIN_PER_H  6'h3c

`endif

// ---- verilog/pto_pkg.sv ----
`default_nettype none
package pto_pkg;

  typedef struct packed {
    logic [16:0] hi;
    logic [7:0]  lo;
  } pto_cnt_t;

  typedef struct packed {
    logic       retain;
    logic       inv2;
    logic       inv1;
    logic       down;
    logic [2:0] scale;
    logic [2:0] func;
  } pto_ctrl_t;

  typedef enum logic [1:0] {
    PTO_ST_TIME = 2'b00,
    PTO_ST_WAIT = 2'b01,
    PTO_ST_HOLD = 2'b11
  } pto_state_t;

endpackage
`default_nettype wire

// ---- verilog/pto_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pto_cfg.svh"

// Contract
// - Output 1 follows count compared with first limit in current scale, except in auto mode 5, where it toggles at second limit.
// - Output 2 follows count compared with second limit in current scale; stays inactive in auto mode 5.
// - Seven scale codes; minute/second tops at 0099.59; code 6 is seconds.
// - Manual mode 1 keeps timing until reset; output 2 pulse time ignored.
// - Manual mode 2 holds at second limit until manual reset.
// - Auto mode 1 adds second limit to total, clears count, resumes.
// - Auto mode 2 stops at second limit, clears when output 2 pulse ends.
// - Auto mode 3 clears at once; display shows limit during output 2 pulse.
// - Auto mode 4 keeps counting; clears when output 2 pulse ends.
// - Auto mode 5 toggles output 1 and clears count at second limit.
// - Manual and software resets load zero when counting up, second limit when down.
// - Each output has a selectable inverted (normally energised) level.
// - Output 1 pulse time up to 9999; zero means indefinite.
// - Output 2 pulse time up to 9999; zero indefinite; expiry drives clears.
// - With retention on, count saved at power loss and restored at power-up.
// - Parameter writes need matching password up to 9999; zero disables check.
// - Gate input runs timing while active, freezes it while inactive.
module pto_timer #(
  parameter int MS_CYC = `PTO_TICK_US * `PTO_CLK_MHZ
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        gate_in,
  input  wire logic        reset_in,
  input  wire logic        power_fail_in,
  input  wire logic [24:0] nv_word_in,
  input  wire logic        nv_valid_in,
  output logic      [24:0] nv_word,
  output logic             nv_save,
  output logic             out1,
  output logic             out2,
  output logic             irq
);

  localparam int MSW = $clog2(MS_CYC);

  if (MS_CYC < 2 || MS_CYC > 1048576) begin : g_bad_ms
    $error("MS_CYC out of range");
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Scale decoding
  // ----------------------------------------------------------------
  function automatic logic [7:0] lo_max(input logic [2:0] sc);
    unique case (sc)
      `PTO_SC_HM, `PTO_SC_MS, `PTO_SC_HM2: lo_max = `PTO_LO59;
      `PTO_SC_SMS: lo_max = `PTO_LO99;
      default:     lo_max = 8'h00;
    endcase
  endfunction

  function automatic logic [16:0] hi_max(input logic [2:0] sc);
    unique case (sc)
      `PTO_SC_HM, `PTO_SC_MS, `PTO_SC_SMS: hi_max = `PTO_HI99;
      `PTO_SC_HM2: hi_max = `PTO_HI9999;
      default:     hi_max = `PTO_HI99999;
    endcase
  endfunction

  function automatic logic [13:0] clip14(input logic [31:0] v);
    clip14 = (v > 32'(`PTO_VAL_MAX)) ? `PTO_VAL_MAX : v[13:0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_old_q, rise;

  assign pin_raw = {power_fail_in, reset_in, gate_in};
  assign rise    = lvl_q & ~lvl_old_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q      <= 3'h0;
      s2_q      <= 3'h0;
      s3_q      <= 3'h0;
      lvl_q     <= 3'h0;
      lvl_old_q <= 3'h0;
    end else begin
      s1_q      <= pin_raw;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      lvl_q     <= (lvl_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      lvl_old_q <= lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic              take, wr_q, rd_q, unlocked, swrst;
  logic [7:0]        a_q;
  logic [31:0]       rdv;
  pto_pkg::pto_ctrl_t ctrl_q;
  pto_pkg::pto_cnt_t  lim1_q, lim2_q, cnt_q, disp_q, nxt, preset;
  logic [13:0]       p1_q, p2_q, pass_q, key_q;
  logic [31:0]       total_q;
  logic [3:0]        ist_q, ien_q, ev, iclr;
  pto_pkg::pto_state_t st_q;
  logic              o1_act_q, o2_act_q, run_en;

  assign take     = hsel & htrans[1] & hready;
  assign unlocked = (pass_q == 14'h0) || (key_q == pass_q);
  assign swrst    = wr_q && a_q == `PTO_CTRL_OFS && hwdata[`PTO_CTRL_SWRST];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      a_q       <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      wr_q      <= take & hwrite;
      rd_q      <= take & ~hwrite;
      a_q       <= take ? haddr[7:0] : a_q;
      hreadyout <= ~(take & ~hwrite);
      hresp     <= 1'b0;
      hrdata    <= rd_q ? rdv : 32'h0;
    end
  end

  always_comb begin
    unique case (a_q)
      `PTO_CTRL_OFS:  rdv = {22'h0, ctrl_q};
      `PTO_LIM1_OFS:  rdv = {7'h0, lim1_q};
      `PTO_LIM2_OFS:  rdv = {7'h0, lim2_q};
      `PTO_PULSE_OFS: rdv = {2'h0, p2_q, 2'h0, p1_q};
      `PTO_UNLK_OFS:  rdv = {31'h0, unlocked};
      `PTO_CNT_OFS:   rdv = {7'h0, cnt_q};
      `PTO_DISP_OFS:  rdv = {7'h0, disp_q};
      `PTO_TOT_OFS:   rdv = total_q;
      `PTO_STAT_OFS:  rdv = {27'h0, st_q == pto_pkg::PTO_ST_HOLD, unlocked,
                             run_en, o2_act_q, o1_act_q};
      `PTO_IST_OFS:   rdv = {28'h0, ist_q};
      `PTO_IEN_OFS:   rdv = {28'h0, ien_q};
      default:        rdv = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '0;
      lim1_q <= '0;
      lim2_q <= '0;
      p1_q   <= 14'h0;
      p2_q   <= 14'h0;
      pass_q <= 14'h0;
      key_q  <= 14'h0;
    end else begin
      if (wr_q && a_q == `PTO_UNLK_OFS) key_q <= clip14(hwdata);
      if (wr_q && unlocked) begin
        unique case (a_q)
          `PTO_CTRL_OFS:  ctrl_q <= hwdata[9:0];
          `PTO_LIM1_OFS:  lim1_q <= hwdata[24:0];
          `PTO_LIM2_OFS:  lim2_q <= hwdata[24:0];
          `PTO_PULSE_OFS: begin
            p1_q <= clip14({18'h0, hwdata[13:0]});
            p2_q <= clip14({18'h0, hwdata[`PTO_P2_LSB +: 14]});
          end
          `PTO_PASS_OFS:  pass_q <= clip14(hwdata);
          default: ;
        endcase
      end
    end
  end

  lock_ctrl_a: assert property (wr_q && !unlocked |=> $stable(ctrl_q))
    else $error("locked write changed ctrl");

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic [MSW-1:0] ms_q;
  logic [3:0]     cs_q;
  logic [6:0]     sec_q;
  logic [5:0]     min_q, hr_q;
  logic           ms_tick, t_cs, t_s, t_m, t_h, step, mrst;

  assign ms_tick = ms_q == MSW'(MS_CYC - 1);
  assign t_cs    = ms_tick & run_en & (cs_q == `PTO_MS_PER_CS - 4'h1);
  assign t_s     = t_cs & (sec_q == `PTO_CS_PER_S - 7'h1);
  assign t_m     = t_s & (min_q == `PTO_S_PER_MIN - 6'h1);
  assign t_h     = t_m & (hr_q == `PTO_MIN_PER_H - 6'h1);

  always_comb begin
    unique case (ctrl_q.scale)
      `PTO_SC_HM, `PTO_SC_HM2, `PTO_SC_M: step = t_m;
      `PTO_SC_MS, `PTO_SC_S:              step = t_s;
      `PTO_SC_SMS:                        step = t_cs;
      default:                            step = t_h;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_q  <= '0;
      cs_q  <= 4'h0;
      sec_q <= 7'h0;
      min_q <= 6'h0;
      hr_q  <= 6'h0;
    end else begin
      ms_q <= ms_tick ? '0 : ms_q + MSW'(1);
      if (mrst) begin
        cs_q  <= 4'h0;
        sec_q <= 7'h0;
        min_q <= 6'h0;
        hr_q  <= 6'h0;
      end else if (ms_tick && run_en) begin
        cs_q <= t_cs ? 4'h0 : cs_q + 4'h1;
        if (t_cs) sec_q <= t_s ? 7'h0 : sec_q + 7'h1;
        if (t_s)  min_q <= t_m ? 6'h0 : min_q + 6'h1;
        if (t_m)  hr_q  <= t_h ? 6'h0 : hr_q + 6'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counting core
  // ----------------------------------------------------------------
  logic        reach1, reach2, r1_q, r2_q, hit1, hit2, p1_end, p2_end, boot_q;
  logic [7:0]  lm;
  logic [16:0] hm;
  logic [13:0] p1c_q, p2c_q;
  logic [31:0] tot_add;

  assign mrst    = rise[1] | swrst;
  assign preset  = ctrl_q.down ? lim2_q : '0;
  assign reach1  = ctrl_q.down ? (cnt_q <= lim1_q) : (cnt_q >= lim1_q);
  assign reach2  = ctrl_q.down ? (cnt_q == '0) : (cnt_q >= lim2_q);
  assign hit1    = reach1 & ~r1_q;
  assign hit2    = reach2 & ~r2_q;
  assign lm      = lo_max(ctrl_q.scale);
  assign hm      = hi_max(ctrl_q.scale);
  assign tot_add = 32'(lim2_q.hi) * 32'(lm + 8'h1) + 32'(lim2_q.lo);
  assign run_en  = lvl_q[0] && st_q != pto_pkg::PTO_ST_HOLD &&
                   !(st_q == pto_pkg::PTO_ST_WAIT && ctrl_q.func == `PTO_FN_AUT2);

  always_comb begin
    nxt = cnt_q;
    if (!ctrl_q.down) begin
      if (cnt_q.hi >= hm && cnt_q.lo >= lm) begin
        nxt = cnt_q;
      end else if (cnt_q.lo >= lm) begin
        nxt.lo = 8'h00;
        nxt.hi = cnt_q.hi + 17'h1;
      end else begin
        nxt.lo = cnt_q.lo + 8'h1;
      end
    end else if (cnt_q.lo != 8'h00) begin
      nxt.lo = cnt_q.lo - 8'h1;
    end else if (cnt_q.hi != 17'h0) begin
      nxt.hi = cnt_q.hi - 17'h1;
      nxt.lo = lm;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q   <= '0;
      st_q    <= pto_pkg::PTO_ST_TIME;
      total_q <= 32'h0;
      boot_q  <= 1'b1;
      r1_q    <= 1'b0;
      r2_q    <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      r1_q   <= reach1;
      r2_q   <= reach2;
      if (boot_q) begin
        if (nv_valid_in) cnt_q <= nv_word_in;
      end else if (mrst) begin
        cnt_q <= preset;
        st_q  <= pto_pkg::PTO_ST_TIME;
      end else begin
        unique case (st_q)
          pto_pkg::PTO_ST_TIME: begin
            if (hit2) begin
              case (ctrl_q.func)
                `PTO_FN_MAN2: st_q <= pto_pkg::PTO_ST_HOLD;
                `PTO_FN_AUT1: begin
                  cnt_q   <= preset;
                  total_q <= total_q + tot_add;
                end
                `PTO_FN_AUT2, `PTO_FN_AUT4: st_q <= pto_pkg::PTO_ST_WAIT;
                `PTO_FN_AUT3, `PTO_FN_AUT5: cnt_q <= preset;
                default: if (step) cnt_q <= nxt;
              endcase
            end else if (step) begin
              cnt_q <= nxt;
            end
          end
          pto_pkg::PTO_ST_WAIT: begin
            if (p2_end) begin
              cnt_q <= preset;
              st_q  <= pto_pkg::PTO_ST_TIME;
            end else if (step) begin
              cnt_q <= nxt;
            end
          end
          pto_pkg::PTO_ST_HOLD: ;
          default: st_q <= pto_pkg::PTO_ST_TIME;
        endcase
      end
    end
  end

  hold_man2_a: assert property (st_q == pto_pkg::PTO_ST_HOLD && !mrst |=> $stable(cnt_q))
    else $error("count moved while held");
  auto1_clr_a: assert property (!boot_q && !mrst && st_q == pto_pkg::PTO_ST_TIME && hit2 &&
                                ctrl_q.func == `PTO_FN_AUT1 |=> cnt_q == $past(preset))
    else $error("auto mode 1 did not clear");
  auto2_stop_a: assert property (st_q == pto_pkg::PTO_ST_WAIT &&
                                 ctrl_q.func == `PTO_FN_AUT2 |-> !run_en)
    else $error("auto mode 2 kept timing");
  wait_end_a: assert property (!boot_q && !mrst && st_q == pto_pkg::PTO_ST_WAIT && p2_end
                               |=> cnt_q == $past(preset) && st_q == pto_pkg::PTO_ST_TIME)
    else $error("pulse end did not clear");
  man_rst_a: assert property (!boot_q && mrst |=> cnt_q == $past(preset))
    else $error("manual reset load wrong");
  gate_frz_a: assert property (!lvl_q[0] && !boot_q && !mrst && !hit2 && !p2_end
                               |=> $stable(cnt_q))
    else $error("count moved while gated off");
  lo_roll_a: assert property (step && !ctrl_q.down && cnt_q.lo == `PTO_LO59 && lm == `PTO_LO59 &&
                              cnt_q.hi < hm && st_q == pto_pkg::PTO_ST_TIME && !hit2 &&
                              !mrst && !boot_q |=> cnt_q.lo == 8'h00)
    else $error("lower field did not roll");

  // ----------------------------------------------------------------
  // Output pulse timers
  // ----------------------------------------------------------------
  assign p1_end = ms_tick & (p1c_q == 14'h1);
  assign p2_end = ms_tick & (p2c_q == 14'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o1_act_q <= 1'b0;
      p1c_q    <= 14'h0;
    end else if (mrst) begin
      o1_act_q <= 1'b0;
      p1c_q    <= 14'h0;
    end else if (hit2 && ctrl_q.func == `PTO_FN_AUT5) begin
      o1_act_q <= ~o1_act_q;
    end else if (hit1 && ctrl_q.func != `PTO_FN_AUT5) begin
      o1_act_q <= 1'b1;
      p1c_q    <= p1_q;
    end else if (p1_end) begin
      o1_act_q <= 1'b0;
      p1c_q    <= 14'h0;
    end else if (ms_tick && p1c_q != 14'h0) begin
      p1c_q <= p1c_q - 14'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o2_act_q <= 1'b0;
      p2c_q    <= 14'h0;
    end else if (mrst) begin
      o2_act_q <= 1'b0;
      p2c_q    <= 14'h0;
    end else if (hit2 && ctrl_q.func != `PTO_FN_AUT5) begin
      o2_act_q <= 1'b1;
      p2c_q    <= (ctrl_q.func == `PTO_FN_MAN1) ? 14'h0 : p2_q;
    end else if (p2_end) begin
      o2_act_q <= 1'b0;
      p2c_q    <= 14'h0;
    end else if (ms_tick && p2c_q != 14'h0) begin
      p2c_q <= p2c_q - 14'h1;
    end
  end

  o1_toggle_a: assert property (!mrst && hit2 && ctrl_q.func == `PTO_FN_AUT5
                                |=> o1_act_q != $past(o1_act_q))
    else $error("auto mode 5 did not toggle");
  o2_set_a: assert property (!mrst && hit2 && ctrl_q.func != `PTO_FN_AUT5 |=> o2_act_q)
    else $error("output 2 not set at limit");
  o1_hold_a: assert property (o1_act_q && p1c_q == 14'h0 && !mrst &&
                              ctrl_q.func != `PTO_FN_AUT5 |=> o1_act_q)
    else $error("indefinite output 1 dropped");

  // ----------------------------------------------------------------
  // Outputs, display, retention, interrupts
  // ----------------------------------------------------------------
  assign ev   = {mrst, p2_end, hit2, hit1};
  assign iclr = (wr_q && a_q == `PTO_ICLR_OFS) ? hwdata[3:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out1    <= 1'b0;
      out2    <= 1'b0;
      disp_q  <= '0;
      nv_word <= 25'h0;
      nv_save <= 1'b0;
      ist_q   <= 4'h0;
      ien_q   <= 4'h0;
      irq     <= 1'b0;
    end else begin
      out1    <= o1_act_q ^ ctrl_q.inv1;
      out2    <= o2_act_q ^ ctrl_q.inv2;
      disp_q  <= (ctrl_q.func == `PTO_FN_AUT3 && o2_act_q) ? lim2_q : cnt_q;
      nv_save <= rise[2] & ctrl_q.retain;
      if (rise[2]) nv_word <= cnt_q;
      ist_q   <= (ist_q & ~iclr) | ev;
      if (wr_q && a_q == `PTO_IEN_OFS) ien_q <= hwdata[3:0];
      irq     <= |(ist_q & ien_q);
    end
  end

  out_pol_a: assert property (out1 == $past(o1_act_q ^ ctrl_q.inv1) &&
                              out2 == $past(o2_act_q ^ ctrl_q.inv2))
    else $error("output polarity wrong");
  disp_a3_a: assert property (ctrl_q.func == `PTO_FN_AUT3 && o2_act_q |=> disp_q == $past(lim2_q))
    else $error("display not showing limit");
  save_a: assert property (rise[2] && ctrl_q.retain |=> nv_save && nv_word == $past(cnt_q))
    else $error("count not saved");

endmodule // pto_timer
`default_nettype wire
